// ### pfm_pkg.sv
// Constants and carrier types of the port pin function multiplexer
package pfm_pkg;

   // Register bus geometry
   localparam int ADDR_W = 3;

   // Register offsets on the plain register port
   localparam logic [2:0] OFF_PA_LO = 3'h0;
   localparam logic [2:0] OFF_PA_HI = 3'h1;
   localparam logic [2:0] OFF_PB_LO = 3'h2;
   localparam logic [2:0] OFF_PB_HI = 3'h3;
   localparam logic [2:0] OFF_PC_LO = 3'h4;
   localparam logic [2:0] OFF_PC_HI = 3'h5;
   localparam logic [2:0] OFF_IN_SRC = 3'h6;
   localparam logic [2:0] OFF_LAST = 3'h6;
   localparam int NUM_REGS = 7;

   // Reset value of every selection register
   localparam logic [7:0] SEL_RST = 8'h00;
   // Implemented bits of the input source register
   localparam logic [7:0] IN_SRC_MASK = 8'h3F;

   // Field codes of a pin selection
   localparam logic [1:0] CODE_00 = 2'h0;
   localparam logic [1:0] CODE_01 = 2'h1;
   localparam logic [1:0] CODE_10 = 2'h2;
   localparam logic [1:0] CODE_11 = 2'h3;

   // Bit positions in the input source register
   localparam int SRC_IRQ_ZERO = 0;
   localparam int SRC_CAPTURE = 1;
   localparam int SRC_CHIP_SEL = 2;

   // Pad side of one 8-pin port
   typedef struct packed {
      logic [7:0] out;
      logic [7:0] oe;
      logic [7:0] pull;
      logic [7:0] analog;
   } pfm_port_t;

   // General I/O side of one port
   typedef struct packed {
      logic [7:0] out;
      logic [7:0] oe;
      logic [7:0] pull;
   } pfm_gpio_t;

   // Software visible selection state
   typedef struct packed {
      logic [7:0] pa_lo;
      logic [7:0] pa_hi;
      logic [7:0] pb_lo;
      logic [7:0] pb_hi;
      logic [7:0] pc_lo;
      logic [7:0] pc_hi;
      logic [5:0] in_src;
   } pfm_sel_t;

   // Peripheral outputs towards the pads
   typedef struct packed {
      logic cs_out;
      logic cs_oe;
      logic dout;
      logic dout_oe;
      logic sck_o;
      logic sck_oe;
      logic sda_o;
      logic sda_oe;
      logic uart_tx;
      logic timer0_output;
      logic timer0_output_inverted;
      logic periodic_timer_output;
      logic periodic_timer_output_inverted;
   } pfm_pout_t;

   // Pad levels handed to the peripherals
   typedef struct packed {
      logic serial_chip_select;
      logic sdi_sda;
      logic sck_scl;
      logic uart_rx;
      logic ext_interrupt_zero;
      logic ext_interrupt_one;
      logic timer0_clock_in;
      logic periodic_timer_capture_in;
      logic periodic_timer_clock_in;
      logic standard_timer_clock_in;
   } pfm_pin_t;

   // Special analog pin hookups
   typedef struct packed {
      logic slow_crystal_in;
      logic slow_crystal_out;
      logic lcd_bias_voltage;
      logic lcd_pump_cap_first;
      logic lcd_pump_cap_second;
      logic adc_reference;
   } pfm_spec_t;

endpackage : pfm_pkg

// ### pfm_regs.sv
// Selection register file behind the plain register port
module pfm_regs (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic [pfm_pkg::ADDR_W-1:0] bus_addr,
   input wire logic [7:0] bus_wdata,
   input wire logic bus_wr,
   input wire logic bus_rd,
   output logic [7:0] bus_rdata,
   output pfm_pkg::pfm_sel_t sel
);
   import pfm_pkg::*;

   logic [7:0] mem [NUM_REGS];
   logic [7:0] next_rdata;

   // Register writes; addresses above the map are dropped
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < NUM_REGS; i++) begin
            mem[i] <= SEL_RST;
         end
      end else if (bus_wr && bus_addr <= OFF_LAST) begin
         if (bus_addr == OFF_IN_SRC) begin
            mem[bus_addr] <= bus_wdata & IN_SRC_MASK;
         end else begin
            mem[bus_addr] <= bus_wdata;
         end
      end
   end

   // Read mux; unmapped reads and idle cycles answer zero
   always_comb begin
      next_rdata = 8'h00;
      if (bus_rd && bus_addr <= OFF_LAST) begin
         next_rdata = mem[bus_addr];
      end
   end

   // Read data stands only in the cycle after the strobe
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         bus_rdata <= 8'h00;
      end else begin
         bus_rdata <= next_rdata;
      end
   end

   // Present the stored fields to the decoder
   assign sel.pa_lo = mem[OFF_PA_LO];
   assign sel.pa_hi = mem[OFF_PA_HI];
   assign sel.pb_lo = mem[OFF_PB_LO];
   assign sel.pb_hi = mem[OFF_PB_HI];
   assign sel.pc_lo = mem[OFF_PC_LO];
   assign sel.pc_hi = mem[OFF_PC_HI];
   assign sel.in_src = mem[OFF_IN_SRC][5:0];

endmodule : pfm_regs

// ### pfm_mux.sv
// Pin function multiplexer for ports A, B and C
module pfm_mux #(
   parameter int unsigned PA7_KEY = 20,
   parameter int unsigned PA7_SEG = 15,
   parameter bit PC_LOW_SEG = 1'b1,
   parameter bit PC_HIGH_PINS = 1'b1,
   parameter bit PC_HIGH_SEG = 1'b1
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic [pfm_pkg::ADDR_W-1:0] bus_addr,
   input wire logic [7:0] bus_wdata,
   input wire logic bus_wr,
   input wire logic bus_rd,
   output logic [7:0] bus_rdata,
   input wire pfm_pkg::pfm_gpio_t gpio_a,
   input wire pfm_pkg::pfm_gpio_t gpio_b,
   input wire pfm_pkg::pfm_gpio_t gpio_c,
   input wire pfm_pkg::pfm_pout_t periph_out,
   output pfm_pkg::pfm_pin_t periph_in,
   input wire logic [7:0] pad_in_a,
   input wire logic [7:0] pad_in_b,
   input wire logic [7:0] pad_in_c,
   output pfm_pkg::pfm_port_t pad_a,
   output pfm_pkg::pfm_port_t pad_b,
   output pfm_pkg::pfm_port_t pad_c,
   output pfm_pkg::pfm_spec_t special,
   output logic [7:0] analog_sel,
   output logic [31:0] key_sel,
   output logic [31:0] seg_sel
);
   import pfm_pkg::*;

   pfm_sel_t sel;
   logic [1:0] ca [8];
   logic [1:0] cb [8];
   logic [1:0] cc [8];

   // Field of pin n, low register holds pins 0..3
   function automatic logic [1:0] pfm_code(input logic [7:0] lo,
                                           input logic [7:0] hi,
                                           input int unsigned n);
      if (n < 4) begin
         return lo[2*n +: 2];
      end
      return hi[2*(n-4) +: 2];
   endfunction : pfm_code

   // Plain general I/O; pull-high only while the pin is an input
   function automatic pfm_port_t pfm_pass(input pfm_gpio_t g);
      pfm_port_t p;
      p.out = g.out;
      p.oe = g.oe;
      p.pull = g.pull & ~g.oe;
      p.analog = 8'h00;
      return p;
   endfunction : pfm_pass

   // Hand a pin to a peripheral output
   function automatic pfm_port_t pfm_drive(input pfm_port_t p,
                                           input int unsigned n,
                                           input logic v,
                                           input logic e);
      pfm_port_t q;
      q = p;
      q.out[n] = v;
      q.oe[n] = e;
      q.pull[n] = 1'b0;
      return q;
   endfunction : pfm_drive

   // Cut driver and pull-high, connect the analog switch
   function automatic pfm_port_t pfm_iso(input pfm_port_t p,
                                         input int unsigned n);
      pfm_port_t q;
      q = p;
      q.out[n] = 1'b0;
      q.oe[n] = 1'b0;
      q.pull[n] = 1'b0;
      q.analog[n] = 1'b1;
      return q;
   endfunction : pfm_iso

   pfm_regs u_regs (
      .sys_clk(sys_clk),
      .rst(rst),
      .bus_addr(bus_addr),
      .bus_wdata(bus_wdata),
      .bus_wr(bus_wr),
      .bus_rd(bus_rd),
      .bus_rdata(bus_rdata),
      .sel(sel)
   );

   // Per-pin codes straight from the registers
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         ca[i] = pfm_code(sel.pa_lo, sel.pa_hi, i);
         cb[i] = pfm_code(sel.pb_lo, sel.pb_hi, i);
         cc[i] = pfm_code(sel.pc_lo, sel.pc_hi, i);
      end
   end

   // Port A pads
   always_comb begin
      pfm_port_t p;
      p = pfm_pass(gpio_a);
      if (ca[0] == CODE_01) begin
         p = pfm_drive(p, 0, periph_out.dout, periph_out.dout_oe);
      end
      if (ca[1] == CODE_01) begin
         p = pfm_drive(p, 1, periph_out.timer0_output, 1'b1);
      end else if (ca[1] == CODE_11) begin
         p = pfm_iso(p, 1);
      end
      if (ca[2] == CODE_01) begin
         p = pfm_drive(p, 2, periph_out.cs_out, periph_out.cs_oe);
      end
      if (ca[3] == CODE_01) begin
         p = pfm_drive(p, 3, periph_out.cs_out, periph_out.cs_oe);
      end else if (ca[3] == CODE_10) begin
         p = pfm_iso(p, 3);
      end
      if (ca[4] == CODE_01) begin
         p = pfm_drive(p, 4, periph_out.dout, periph_out.dout_oe);
      end else if (ca[4] == CODE_10) begin
         p = pfm_iso(p, 4);
      end
      if (ca[5] == CODE_01) begin
         p = pfm_drive(p, 5, periph_out.timer0_output_inverted, 1'b1);
      end else if (ca[5] == CODE_11) begin
         p = pfm_iso(p, 5);
      end
      if (ca[6] == CODE_11) begin
         p = pfm_iso(p, 6);
      end
      if (ca[7][1]) begin
         p = pfm_iso(p, 7);
      end
      pad_a = p;
   end

   // Port B pads; the high nibble is key or analog on 1x codes
   always_comb begin
      pfm_port_t p;
      p = pfm_pass(gpio_b);
      case (cb[0])
         CODE_01: p = pfm_drive(p, 0, periph_out.sda_o,
                                periph_out.sda_oe);
         CODE_10, CODE_11: p = pfm_iso(p, 0);
         default: ;
      endcase
      case (cb[1])
         CODE_01: p = pfm_drive(p, 1, periph_out.sck_o,
                                periph_out.sck_oe);
         CODE_11: p = pfm_iso(p, 1);
         default: ;
      endcase
      case (cb[2])
         CODE_01: p = pfm_drive(p, 2, periph_out.uart_tx, 1'b1);
         CODE_10: p = pfm_drive(p, 2, periph_out.periodic_timer_output,
                                1'b1);
         CODE_11: p = pfm_iso(p, 2);
         default: ;
      endcase
      if (cb[3] == CODE_11) begin
         p = pfm_iso(p, 3);
      end
      if (cb[4] == CODE_01) begin
         p = pfm_drive(p, 4, periph_out.periodic_timer_output_inverted,
                       1'b1);
      end
      for (int i = 4; i < 8; i++) begin
         if (cb[i][1]) begin
            p = pfm_iso(p, i);
         end
      end
      pad_b = p;
   end

   // Port C pads; segment codes depend on the variant
   always_comb begin
      pfm_port_t p;
      p = pfm_pass(gpio_c);
      for (int i = 0; i < 4; i++) begin
         if (cc[i] == CODE_10 || (cc[i] == CODE_11 && PC_LOW_SEG)) begin
            p = pfm_iso(p, i);
         end
      end
      for (int i = 6; i < 8; i++) begin
         if (!PC_HIGH_PINS) begin
            p.out[i] = 1'b0; // Absent pins are left inert
            p.oe[i] = 1'b0;
            p.pull[i] = 1'b0;
         end else if (cc[i] == CODE_10 ||
                      (cc[i] == CODE_11 && PC_HIGH_SEG)) begin
            p = pfm_iso(p, i);
         end
      end
      pad_c = p;
   end

   // Crystal, LCD and reference hookups
   always_comb begin
      special.slow_crystal_in = (ca[3] == CODE_10);
      special.slow_crystal_out = (ca[4] == CODE_10);
      special.lcd_bias_voltage = (ca[1] == CODE_11);
      special.lcd_pump_cap_first = (ca[5] == CODE_11);
      special.lcd_pump_cap_second = (ca[6] == CODE_11);
      special.adc_reference = (cb[0] == CODE_10);
   end

   // Analog inputs 0..7 all sit on port B code 11
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         analog_sel[i] = (cb[i] == CODE_11);
      end
   end

   // Touch key and segment map, indexed by key or segment number
   always_comb begin
      key_sel = 32'h0000_0000;
      seg_sel = 32'h0000_0000;
      key_sel[PA7_KEY] = (ca[7] == CODE_10);
      seg_sel[PA7_SEG] = (ca[7] == CODE_11);
      for (int i = 0; i < 4; i++) begin
         key_sel[1+i] = (cb[4+i] == CODE_10);
         key_sel[5+i] = (cc[i] == CODE_10);
         seg_sel[i] = (cc[i] == CODE_11) && PC_LOW_SEG;
      end
      for (int i = 6; i < 8; i++) begin
         key_sel[5+i] = (cc[i] == CODE_10) && PC_HIGH_PINS;
         seg_sel[i] = (cc[i] == CODE_11) && PC_HIGH_PINS && PC_HIGH_SEG;
      end
   end

   // Peripheral inputs; chip select, data, clock and receive sit high unless in code 01,
   // while interrupt, timer clock and capture inputs follow the pad in general I/O codes
   always_comb begin
      periph_in.serial_chip_select = sel.in_src[SRC_CHIP_SEL] ?
         ((ca[2] == CODE_01) ? pad_in_a[2] : 1'b1) :
         ((ca[3] == CODE_01) ? pad_in_a[3] : 1'b1);
      periph_in.sdi_sda = (cb[0] == CODE_01) ? pad_in_b[0] : 1'b1;
      periph_in.sck_scl = (cb[1] == CODE_01) ? pad_in_b[1] : 1'b1;
      periph_in.uart_rx = (cb[3] == CODE_01) ? pad_in_b[3] : 1'b1;
      periph_in.ext_interrupt_zero = sel.in_src[SRC_IRQ_ZERO] ?
         (!cb[3][0] && pad_in_b[3]) :
         ((ca[6] != CODE_11) && pad_in_a[6]);
      periph_in.ext_interrupt_one = !cb[7][1] && pad_in_b[7];
      periph_in.timer0_clock_in = (ca[6] != CODE_11) && pad_in_a[6];
      periph_in.periodic_timer_capture_in = sel.in_src[SRC_CAPTURE] ?
         ((cb[4] == CODE_00) && pad_in_b[4]) :
         ((cb[2] == CODE_00) && pad_in_b[2]);
      periph_in.periodic_timer_clock_in = !cb[6][1] && pad_in_b[6];
      periph_in.standard_timer_clock_in = !cb[5][1] && pad_in_b[5];
   end

   default clocking cb_main @(posedge sys_clk);
   endclocking
   default disable iff (rst);

   a_pa3_crystal: assert property ((ca[3] == CODE_10) |->
      (special.slow_crystal_in && !pad_a.oe[3] && !pad_a.pull[3]))
      else $error("PA3 crystal input not isolated");
   a_pa3_gpio: assert property ((ca[3] == CODE_11) |->
      (pad_a.oe[3] == gpio_a.oe[3] && pad_a.out[3] == gpio_a.out[3]))
      else $error("PA3 code 11 is not general I/O");
   a_pa2_select: assert property ((ca[2] == CODE_01) |->
      (pad_a.out[2] == periph_out.cs_out && pad_a.oe[2] == periph_out.cs_oe))
      else $error("PA2 chip select not routed");
   a_pa1_bias: assert property ((ca[1] == CODE_11) |->
      (special.lcd_bias_voltage && pad_a.analog[1] && !pad_a.oe[1]))
      else $error("PA1 bias pin not isolated");
   a_pa0_data: assert property ((ca[0] == CODE_01) |->
      (pad_a.out[0] == periph_out.dout && pad_a.oe[0] == periph_out.dout_oe))
      else $error("PA0 serial data not routed");
   a_pa7_key: assert property ((ca[7] == CODE_10) |->
      (key_sel[PA7_KEY] && !seg_sel[PA7_SEG] && !pad_a.oe[7]))
      else $error("PA7 touch key not selected");
   a_pa6_int_src: assert property ((ca[6] != CODE_11 &&
      !sel.in_src[SRC_IRQ_ZERO]) |->
      (periph_in.ext_interrupt_zero == pad_in_a[6]))
      else $error("PA6 interrupt input lost in I/O code");
   a_pa5_inverted: assert property ((ca[5] == CODE_01) |->
      (pad_a.oe[5] && pad_a.out[5] == periph_out.timer0_output_inverted))
      else $error("PA5 inverted timer output not routed");
   a_pa4_crystal: assert property ((ca[4] == CODE_10) |->
      (special.slow_crystal_out && !pad_a.oe[4] && !pad_a.pull[4]))
      else $error("PA4 crystal output not isolated");
   a_pb3_rx: assert property ((cb[3] == CODE_01) |->
      (periph_in.uart_rx == pad_in_b[3] && !analog_sel[3]))
      else $error("PB3 receive line not routed");
   a_pb2_timer: assert property ((cb[2] == CODE_10) |->
      (pad_b.oe[2] && pad_b.out[2] == periph_out.periodic_timer_output))
      else $error("PB2 periodic timer output not routed");
   a_pb1_clock: assert property ((cb[1] == CODE_01) |->
      (pad_b.oe[1] == periph_out.sck_oe && periph_in.sck_scl == pad_in_b[1]))
      else $error("PB1 serial clock not routed");
   a_pb0_ref: assert property ((cb[0] == CODE_10) |->
      (special.adc_reference && !analog_sel[0] && !pad_b.oe[0]))
      else $error("PB0 reference input not isolated");
   a_pb7_key: assert property ((cb[7] == CODE_10) |->
      (key_sel[4] && !pad_b.oe[7] && !pad_b.pull[7]))
      else $error("PB7 touch key not selected");
   a_pb6_analog: assert property ((cb[6] == CODE_11) |->
      (analog_sel[6] && !key_sel[3] && pad_b.analog[6]))
      else $error("PB6 analog input not selected");
   a_pb5_clock: assert property ((cb[5] == CODE_01) |->
      (periph_in.standard_timer_clock_in == pad_in_b[5]))
      else $error("PB5 timer clock lost in I/O code");
   a_pb4_inverted: assert property ((cb[4] == CODE_01) |->
      (pad_b.out[4] == periph_out.periodic_timer_output_inverted))
      else $error("PB4 inverted timer output not routed");
   a_pc0_segment: assert property ((cc[0] == CODE_11) |->
      (seg_sel[0] == PC_LOW_SEG && pad_c.analog[0] == PC_LOW_SEG))
      else $error("PC0 segment choice wrong for variant");
   a_pc7_key: assert property ((cc[7] == CODE_10) |->
      (key_sel[12] == PC_HIGH_PINS))
      else $error("PC7 touch key choice wrong for variant");
   a_write_readback: assert property ((bus_wr && bus_addr == OFF_PB_HI)
      ##1 (bus_rd && !bus_wr && bus_addr == OFF_PB_HI)
      |=> (bus_rdata == $past(bus_wdata, 2)))
      else $error("Selection register read back differs");
   a_reset_clear: assert property ($fell(rst) |->
      (sel.pa_lo == SEL_RST && sel.pb_hi == SEL_RST && sel.pc_hi == SEL_RST))
      else $error("Selection register not cleared by reset");
   a_cap_source: assert property ((sel.in_src[SRC_CAPTURE] &&
      cb[4] == CODE_00) |->
      (periph_in.periodic_timer_capture_in == pad_in_b[4]))
      else $error("Capture input source not followed");

endmodule : pfm_mux

// ### pfm_far_side.sv
// Far side model: on-chip peripherals and the resolved pad wire levels
module pfm_far_side (
   input wire logic per_en,
   input wire pfm_pkg::pfm_port_t pad_a,
   input wire pfm_pkg::pfm_port_t pad_b,
   input wire pfm_pkg::pfm_port_t pad_c,
   input wire logic [7:0] ext_a,
   input wire logic [7:0] ext_b,
   input wire logic [7:0] ext_c,
   output pfm_pkg::pfm_pout_t periph_out,
   output logic [7:0] pad_in_a,
   output logic [7:0] pad_in_b,
   output logic [7:0] pad_in_c
);
   timeunit 1ns;
   timeprecision 100ps;
   import pfm_pkg::*;

   // Driven pin wins, else pull-high, else whatever the board applies
   function automatic logic [7:0] lvl(input pfm_port_t p,
                                      input logic [7:0] e);
      return (p.oe & p.out) | (~p.oe & p.pull) | (~p.oe & ~p.pull & e);
   endfunction : lvl

   // Peripherals only drive once software has enabled them
   assign periph_out = per_en ? '1 : '0;

   // Wire levels fed back to the mux inputs
   assign pad_in_a = lvl(pad_a, ext_a);
   assign pad_in_b = lvl(pad_b, ext_b);
   assign pad_in_c = lvl(pad_c, ext_c);
endmodule : pfm_far_side

// ### test_pfm_mux.sv
// Self-checking testbench of the port pin function multiplexer
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin \
   fail_count++; $display("[ERR] %s exp %h got %h", nm, e, g); end end
module test_pfm_mux;
   timeunit 1ns;
   timeprecision 100ps;
   import pfm_pkg::*;
   logic sys_clk, rst, bus_wr, bus_rd, per_en;
   logic [ADDR_W-1:0] bus_addr;
   logic [7:0] bus_wdata, bus_rdata, analog_sel, pad_in_a, pad_in_b, pad_in_c;
   logic [7:0] ext_a, ext_b, ext_c;
   logic [31:0] key_sel, seg_sel;
   pfm_gpio_t gpio_a, gpio_b, gpio_c;
   pfm_pout_t periph_out;
   pfm_pin_t periph_in;
   pfm_port_t pad_a, pad_b, pad_c;
   pfm_spec_t special;
   int fail_count, comparisons;
   // Per pin and code: G general I/O, P peripheral, A isolated, X input only
   string cls [3][8] = '{
      '{"GPGG", "GPGA", "GPGG", "GPAG", "GPAG", "GPGA", "GGGA", "GGAA"},
      '{"GPAA", "GPGA", "GPPA", "GXGA", "GPAA", "GGAA", "GGAA", "GGAA"},
      '{"GGAA", "GGAA", "GGAA", "GGAA", "GGGG", "GGGG", "GGAA", "GGAA"}};
   int kidx [3][8] = '{'{-1, -1, -1, -1, -1, -1, -1, 20},
      '{-1, -1, -1, -1, 1, 2, 3, 4}, '{5, 6, 7, 8, -1, -1, 11, 12}};
   int sidx [3][8] = '{'{-1, -1, -1, -1, -1, -1, -1, 15},
      '{-1, -1, -1, -1, -1, -1, -1, -1}, '{0, 1, 2, 3, -1, -1, 6, 7}};

   pfm_mux pfm_mux_inst (.sys_clk(sys_clk), .rst(rst), .bus_addr(bus_addr),
      .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
      .bus_rdata(bus_rdata), .gpio_a(gpio_a), .gpio_b(gpio_b),
      .gpio_c(gpio_c), .periph_out(periph_out), .periph_in(periph_in),
      .pad_in_a(pad_in_a), .pad_in_b(pad_in_b), .pad_in_c(pad_in_c),
      .pad_a(pad_a), .pad_b(pad_b), .pad_c(pad_c), .special(special),
      .analog_sel(analog_sel), .key_sel(key_sel), .seg_sel(seg_sel));
   pfm_far_side pfm_far_side_inst (.per_en(per_en), .pad_a(pad_a),
      .pad_b(pad_b), .pad_c(pad_c), .ext_a(ext_a), .ext_b(ext_b),
      .ext_c(ext_c), .periph_out(periph_out), .pad_in_a(pad_in_a),
      .pad_in_b(pad_in_b), .pad_in_c(pad_in_c));

   // 200 MHz system clock
   initial begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end

   // One-cycle write strobe
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      bus_addr <= a;
      bus_wdata <= d;
      bus_wr <= 1'b1;
      @(posedge sys_clk);
      bus_wr <= 1'b0;
      #1;
   endtask : wr

   // Read data is only valid in the cycle after the strobe
   task automatic rd(input logic [2:0] a, output logic [7:0] d);
      @(posedge sys_clk);
      bus_addr <= a;
      bus_rd <= 1'b1;
      @(posedge sys_clk);
      bus_rd <= 1'b0;
      #1 d = bus_rdata;
   endtask : rd

   // Board-side hookups expected for a pin and code
   function automatic logic [5:0] spec_exp(input int po, pi, co);
      case (po * 64 + pi * 8 + co)
         26: return 6'h20;
         34: return 6'h10;
         11: return 6'h08;
         43: return 6'h04;
         51: return 6'h02;
         66: return 6'h01;
         default: return 6'h00;
      endcase
   endfunction : spec_exp

   task automatic t_reset;
      logic [7:0] v;
      for (int i = 0; i < 8; i++) begin
         rd(i[2:0], v);
         `CHK("reset value", 8'h00, v)
      end
      @(posedge sys_clk);
      #1 `CHK("rdata after read", 8'h00, bus_rdata)
      `CHK("reset pull a", 8'hFF, pad_a.pull)
      `CHK("reset oe c", 8'h00, pad_c.oe)
      $display("test reset done");
   endtask : t_reset

   task automatic t_regs;
      logic [7:0] v;
      for (int i = 0; i < 6; i++) begin
         wr(i[2:0], 8'hA5 ^ i[7:0]);
         rd(i[2:0], v);
         `CHK("reg readback", 8'hA5 ^ i[7:0], v)
         wr(i[2:0], 8'h00);
      end
      // Write then read with no gap; the new value must come back
      @(posedge sys_clk);
      bus_addr <= OFF_PB_HI;
      bus_wdata <= 8'h3C;
      bus_wr <= 1'b1;
      @(posedge sys_clk);
      bus_wr <= 1'b0;
      bus_rd <= 1'b1;
      @(posedge sys_clk);
      bus_rd <= 1'b0;
      #1 `CHK("back to back", 8'h3C, bus_rdata)
      wr(OFF_PB_HI, 8'h00);
      wr(OFF_IN_SRC, 8'hFF);
      rd(OFF_IN_SRC, v);
      `CHK("input source", 8'h3F, v)
      wr(OFF_IN_SRC, 8'h00);
      wr(3'h7, 8'h5A);
      rd(3'h7, v);
      `CHK("unmapped", 8'h00, v)
      $display("test registers done");
   endtask : t_regs

   // Every code of every field; peripheral enabled only after selection
   task automatic t_pins;
      pfm_port_t p;
      byte c;
      logic [3:0] e;
      int k, s;
      for (int po = 0; po < 3; po++) begin
         for (int pi = 0; pi < 8; pi++) begin
            for (int co = 0; co < 4; co++) begin
               wr(3'(po * 2 + pi / 4), 8'(co << ((pi % 4) * 2)));
               @(posedge sys_clk);
               per_en <= 1'b1;
               #1;
               p = (po == 0) ? pad_a : (po == 1) ? pad_b : pad_c;
               c = cls[po][pi][co];
               e = (c == "G") ? 4'h2 : (c == "P") ? 4'hC : 4'h1;
               k = kidx[po][pi];
               s = sidx[po][pi];
               if (c != "X") begin
                  `CHK("pin mode", e, {p.out[pi] & p.oe[pi], p.oe[pi],
                     p.pull[pi], p.analog[pi]})
               end
               // Pin mode above also
               `CHK("key sel", (co == 2 && k >= 0) ? 32'h1 << k : 32'h0,
                  key_sel)
               `CHK("seg sel", (co == 3 && s >= 0) ? 32'h1 << s : 32'h0,
                  seg_sel)
               `CHK("analog sel", (po == 1 && co == 3) ? 8'h01 << pi : 8'h00,
                  analog_sel)
               `CHK("special", spec_exp(po, pi, co), special)
               @(posedge sys_clk);
               per_en <= 1'b0;
               wr(3'(po * 2 + pi / 4), 8'h00);
            end
         end
      end
      $display("test pins done");
   endtask : t_pins

   // Shared inputs keep seeing the pad in general I/O codes
   task automatic t_inputs;
      @(posedge sys_clk);
      gpio_a.pull <= 8'h00;
      gpio_b.pull <= 8'h00;
      ext_a <= 8'h40;
      ext_b <= 8'h00;
      #1 `CHK("irq0 from pa6", 1'b1, periph_in.ext_interrupt_zero)
      `CHK("rx idle", 1'b1, periph_in.uart_rx)
      `CHK("cs idle", 1'b1, periph_in.serial_chip_select)
      wr(OFF_PA_LO, 8'h40);
      `CHK("cs from pa3", 1'b0, periph_in.serial_chip_select)
      wr(OFF_PA_LO, 8'h00);
      wr(OFF_IN_SRC, 8'h01);
      `CHK("irq0 from pb3 low", 1'b0, periph_in.ext_interrupt_zero)
      @(posedge sys_clk);
      ext_b <= 8'h08;
      #1 `CHK("irq0 from pb3 high", 1'b1, periph_in.ext_interrupt_zero)
      wr(OFF_PB_LO, 8'h40);
      `CHK("rx high", 1'b1, periph_in.uart_rx)
      `CHK("irq0 unselected", 1'b0, periph_in.ext_interrupt_zero)
      @(posedge sys_clk);
      ext_b <= 8'h00;
      #1 `CHK("rx low", 1'b0, periph_in.uart_rx)
      wr(OFF_PB_LO, 8'h00);
      wr(OFF_IN_SRC, 8'h00);
      $display("test inputs done");
   endtask : t_inputs

   task automatic finish_test;
      $display("comparisons %0d mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : finish_test

   // Cuts a hang short; the run needs well under 2000 cycles
   initial begin
      #50000;
      fail_count++;
      finish_test();
   end

   initial begin
      rst = 1'b1;
      {bus_addr, bus_wdata, bus_wr, bus_rd, per_en} = '0;
      {ext_a, ext_b, ext_c} = 24'h000000;
      gpio_a = '{out: 8'h00, oe: 8'h00, pull: 8'hFF};
      gpio_b = gpio_a;
      gpio_c = gpio_a;
      fail_count = 0;
      comparisons = 0;
      repeat (6) @(posedge sys_clk);
      rst <= 1'b0;
      t_reset();
      t_regs();
      t_pins();
      t_inputs();
      finish_test();
   end
endmodule : test_pfm_mux
